// ===== testbench/compact_ext_instr_exec_tb.sv
// self-checking bench for the compact extend, load/store and multiply executor
module compact_ext_instr_exec_tb
   import compact_ext_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int XW = XLEN_WIDE;
   typedef struct packed {
      logic [15:0]   ins;
      logic [XW-1:0] a;
      logic [XW-1:0] b;
      logic [XW-1:0] res;
   } row_s;
   logic sys_clk, nrst, instr_valid, instr_ready, mem_req, mem_gnt, mem_we, mem_half;
   logic mem_rvalid, rf_we, instr_illegal;
   logic [15:0]   instr, mem_wdata, mem_rdata;
   logic [4:0]    rf_raddr_a, rf_raddr_b, rf_waddr;
   logic [XW-1:0] rf_rdata_a, rf_rdata_b, mem_addr, rf_wdata;
   logic [1:0]    delay;
   int            mismatches, samples_checked, cyc;
   logic [15:0]   bad [5] = '{16'h9DF9, 16'h9DFD, 16'h8D74, 16'h0000, 16'h9DE2};
   row_s rows [9] = '{
      '{16'h9DE1, 64'hFFFF_FFFF_FFFF_FF80, 64'h0, 64'h80},
      '{16'h9DE5, 64'h1280, 64'h0, 64'hFFFF_FFFF_FFFF_FF80},
      '{16'h9FE5, 64'hFFFF_0000_0000_007F, 64'h0, 64'h7F},
      '{16'h9DE9, 64'hFFFF_FFFF_FFFF_8001, 64'h0, 64'h8001},
      '{16'h9C6D, 64'h1_8000, 64'h0, 64'hFFFF_FFFF_FFFF_8000},
      '{16'h9DF1, 64'hFFFF_FFFF_8000_0001, 64'h0, 64'h8000_0001},
      '{16'h9DF5, 64'h0123_4567_89AB_CDEF, 64'h0, 64'hFEDC_BA98_7654_3210},
      '{16'h9DD5, 64'h1_0000_0003, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFE_FFFF_FFFD},
      '{16'h9DD5, 64'h1_0000_0000, 64'h1_0000_0000, 64'h0}};

   compact_ext_instr_exec #(.XLEN(XW), .HAS_MUL(1'b1)) dut_u (
      .sys_clk, .nrst, .instr_valid, .instr, .instr_ready, .rf_raddr_a, .rf_raddr_b,
      .rf_rdata_a, .rf_rdata_b, .mem_req, .mem_gnt, .mem_we, .mem_half, .mem_addr,
      .mem_wdata, .mem_rvalid, .mem_rdata, .rf_we, .rf_waddr, .rf_wdata, .instr_illegal);
   mem_rf_model #(.XLEN(XW)) mdl_u (
      .sys_clk, .nrst, .delay, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a, .rf_rdata_b,
      .rf_we, .rf_waddr, .rf_wdata, .mem_req, .mem_gnt, .mem_we, .mem_half, .mem_addr,
      .mem_wdata, .mem_rvalid, .mem_rdata);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic chk_word(input logic [XW-1:0] got, input logic [XW-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({63'h0, got}, {63'h0, exp});
   endtask : chk_bit

   // offers one instruction at a falling edge, returns at the falling edge after it is taken;
   // valid stays up so the next call can follow at once, callers drop it where needed
   task automatic issue(input logic [15:0] ins);
      int n;
      n = 0;
      instr_valid = 1'b1;
      instr = ins;
      while (instr_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
   endtask : issue

   task automatic run_mem(input logic [15:0] ins, input logic [XW-1:0] adr, input logic we,
                          input logic half, input logic [1:0] dl);
      int n;
      n = 0;
      delay = dl;
      issue(ins);
      instr_valid = 1'b0;
      chk_bit(mem_req, 1'b1);
      chk_bit(instr_ready, 1'b0);
      chk_bit(mem_we, we);
      chk_bit(mem_half, half);
      while (!(rf_we === 1'b1 || (we && instr_ready === 1'b1)) && n < 20) begin
         if (mem_req === 1'b1) chk_word(mem_addr, adr);
         @(negedge sys_clk);
         n++;
      end
      chk_bit(n < 20, 1'b1);
   endtask : run_mem

   initial begin
      nrst = 1'b0;
      instr_valid = 1'b0;
      instr = 16'h0000;
      delay = 2'h0;
      repeat (4) @(negedge sys_clk);
      chk_bit(instr_ready, 1'b1);
      chk_bit(mem_req | rf_we | instr_illegal, 1'b0);
      nrst = 1'b1;
      foreach (rows[i]) begin
         mdl_u.regs[{2'h1, rows[i].ins[4:2]}] = rows[i].b;
         mdl_u.regs[{2'h1, rows[i].ins[9:7]}] = rows[i].a;
         issue(rows[i].ins);
         chk_bit(rf_we, 1'b1);
         chk_word({59'h0, rf_waddr}, {59'h0, 2'h1, rows[i].ins[9:7]});
         chk_word(rf_wdata, rows[i].res);
      end
      foreach (bad[i]) begin
         issue(bad[i]);
         chk_bit(instr_illegal, 1'b1);
         chk_bit(rf_we | mem_req, 1'b0);
      end
      // back-to-back unary ops, valid held across both takes
      mdl_u.regs[11] = 64'h1FF;
      mdl_u.regs[15] = 64'hFFFF_FFFF_0000_ABCD;
      instr_valid = 1'b1;
      instr = 16'h9DE1;
      @(negedge sys_clk);
      instr = 16'h9FE9;
      chk_word(rf_wdata, 64'hFF);
      @(negedge sys_clk);
      instr_valid = 1'b0;
      chk_word({59'h0, rf_waddr}, 64'hF);
      chk_word(rf_wdata, 64'hABCD);
      @(negedge sys_clk);
      chk_bit(rf_we, 1'b0);
      // loads through base x10, destination x12
      mdl_u.regs[10] = 64'h40;
      mdl_u.regs[13] = 64'hFFFF_FFFF_FFFF_A5C3;
      mdl_u.mem[8'h42] = 8'h34;
      mdl_u.mem[8'h43] = 8'h92;
      run_mem(16'h8530, 64'h42, 1'b0, 1'b1, 2'h0);
      chk_word({59'h0, rf_waddr}, 64'hC);
      chk_word(rf_wdata, 64'h9234);
      run_mem(16'h8570, 64'h42, 1'b0, 1'b1, 2'h2);
      chk_word(rf_wdata, 64'hFFFF_FFFF_FFFF_9234);
      // stores from x13, only the addressed lanes may change
      for (int k = 8'h40; k < 8'h48; k++) mdl_u.mem[k] = 8'h00;
      run_mem(16'h8974, 64'h43, 1'b1, 1'b0, 2'h1);
      chk_word({mdl_u.mem[8'h44], mdl_u.mem[8'h43], mdl_u.mem[8'h42]}, 64'hC300);
      run_mem(16'h8954, 64'h41, 1'b1, 1'b0, 2'h0);
      chk_word({mdl_u.mem[8'h41], mdl_u.mem[8'h40]}, 64'hC300);
      run_mem(16'h8D34, 64'h42, 1'b1, 1'b1, 2'h2);
      chk_word({mdl_u.mem[8'h44], mdl_u.mem[8'h43], mdl_u.mem[8'h42]}, 64'hA5C3);
      // reset while a slow load waits for its grant
      delay = 2'h3;
      issue(16'h8530);
      instr_valid = 1'b0;
      nrst = 1'b0;
      @(negedge sys_clk);
      chk_bit(instr_ready, 1'b1);
      chk_bit(mem_req | rf_we, 1'b0);
      nrst = 1'b1;
      issue(16'h9DF5);
      chk_word(rf_wdata, ~mdl_u.regs[11]);
      wrap_up();
   end
endmodule : compact_ext_instr_exec_tb

// ===== testbench/mem_rf_model.sv
// register file and data memory standing at the executor's far side
module mem_rf_model
   import compact_ext_pkg::*;
#(
   parameter int XLEN = XLEN_WIDE
) (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic [1:0]       delay,
   input  wire logic [4:0]       rf_raddr_a,
   input  wire logic [4:0]       rf_raddr_b,
   output logic      [XLEN-1:0]  rf_rdata_a,
   output logic      [XLEN-1:0]  rf_rdata_b,
   input  wire logic             rf_we,
   input  wire logic [4:0]       rf_waddr,
   input  wire logic [XLEN-1:0]  rf_wdata,
   input  wire logic             mem_req,
   output logic                  mem_gnt,
   input  wire logic             mem_we,
   input  wire logic             mem_half,
   input  wire logic [XLEN-1:0]  mem_addr,
   input  wire logic [15:0]      mem_wdata,
   output logic                  mem_rvalid,
   output logic      [15:0]      mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [XLEN-1:0]  regs [32];
   logic [7:0]       mem  [256];
   logic [1:0]       age_q;
   logic [1:0]       rcnt_q;
   logic             pend_q;
   logic [7:0]       la_q;
   assign rf_rdata_a = regs[rf_raddr_a];
   assign rf_rdata_b = regs[rf_raddr_b];
   // grant after the request has waited delay cycles
   assign mem_gnt = mem_req && (age_q == delay);
   always @(posedge sys_clk) begin
      if (rf_we) regs[rf_waddr] <= rf_wdata;
   end
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         age_q      <= 2'h0;
         rcnt_q     <= 2'h0;
         pend_q     <= 1'b0;
         la_q       <= 8'h00;
         mem_rvalid <= 1'b0;
         mem_rdata  <= 16'h5A5A;
      end else begin
         mem_rvalid <= 1'b0;
         // idle read bus keeps toggling so stale data is never mistaken for an answer
         mem_rdata  <= ~mem_rdata;
         age_q      <= (mem_req && !mem_gnt) ? age_q + 2'h1 : 2'h0;
         if (pend_q && rcnt_q == 2'h0) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= {mem[la_q + 8'h01], mem[la_q]};
            pend_q     <= 1'b0;
         end else if (pend_q) rcnt_q <= rcnt_q - 2'h1;
         if (mem_gnt && mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata[7:0];
            if (mem_half) mem[mem_addr[7:0] + 8'h01] <= mem_wdata[15:8];
         end else if (mem_gnt) begin
            pend_q <= 1'b1;
            rcnt_q <= delay;
            la_q   <= mem_addr[7:0];
         end
      end
   end
endmodule : mem_rf_model

// ===== verilog/compact_ext_instr_exec.sv
// executor for compact halfword loads, short stores, extensions, complement and multiply
// What this block does
// - unsigned halfword load zero-extends sixteen bits
// - signed halfword load sign-extends sixteen bits
// - address is base plus zero-extended offset
// - register fields select only x8 to x15
// - halfword offset bit1 from bit5, bit0 zero
// - byte store offset bits from bits 5, 6
// - byte store writes low source byte only
// - halfword store writes low source halfword only
// - unary ops write back to same register
// - byte zero-extend clears bits above seven
// - byte sign-extend copies bit seven upward
// - halfword zero-extend clears bits above fifteen
// - halfword sign-extend copies bit fifteen upward
// - word zero-extend exists only on 64-bit
// - complement inverts register and writes back
// - multiply keeps low product bits into first
// - multiply exists only with multiply support
module compact_ext_instr_exec
   import compact_ext_pkg::*;
#(
   parameter int XLEN    = XLEN_DEFAULT,
   parameter bit HAS_MUL = 1'b1
) (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic             instr_valid,
   input  wire logic [15:0]      instr,
   output logic                  instr_ready,
   output logic      [4:0]       rf_raddr_a,
   output logic      [4:0]       rf_raddr_b,
   input  wire logic [XLEN-1:0]  rf_rdata_a,
   input  wire logic [XLEN-1:0]  rf_rdata_b,
   output logic                  mem_req,
   input  wire logic             mem_gnt,
   output logic                  mem_we,
   output logic                  mem_half,
   output logic      [XLEN-1:0]  mem_addr,
   output logic      [15:0]      mem_wdata,
   input  wire logic             mem_rvalid,
   input  wire logic [15:0]      mem_rdata,
   output logic                  rf_we,
   output logic      [4:0]       rf_waddr,
   output logic      [XLEN-1:0]  rf_wdata,
   output logic                  instr_illegal
);

   if (XLEN != XLEN_DEFAULT && XLEN != XLEN_WIDE) begin : g_bad_xlen
      $error("XLEN must be 32 or 64");
   end

   state_e           state_q;
   state_e           state_d;
   op_e              op_now;
   op_e              op_q;
   op_e              unit_op;
   logic             accept;
   logic             legal_now;
   logic [1:0]       ofs_now;
   logic [XLEN-1:0]  addr_now;
   logic [XLEN-1:0]  unit_result;
   logic             rf_we_d;
   logic [4:0]       dst_q;
   logic             rf_we_q;
   logic [4:0]       rf_waddr_q;
   logic [XLEN-1:0]  rf_wdata_q;
   logic             illegal_q;
   logic             mem_we_q;
   logic             mem_half_q;
   logic [XLEN-1:0]  mem_addr_q;
   logic [15:0]      mem_wdata_q;
   logic [XLEN-1:0]  last_a_q;
   logic [XLEN-1:0]  last_b_q;
   logic [15:0]      last_mem_q;

   // the word zero-extend needs a 64-bit datapath; multiply needs the multiplier built in
   function automatic logic op_legal(input op_e op);
      op_legal = (op != OP_NONE)
               && !(op == OP_ZEXTW && XLEN != XLEN_WIDE)
               && !(op == OP_MUL && !HAS_MUL);
   endfunction : op_legal

   // decode -------------------------------------------------------------
   assign op_now    = decode_op(instr);
   assign legal_now = op_legal(op_now);
   assign accept    = instr_valid && instr_ready;
   // one instruction in flight; a stalled memory port holds off fetch
   assign instr_ready = (state_q == ST_IDLE);

   // the combined field feeds port a for every form, so unary ops read and write one register
   assign rf_raddr_a = compact_reg(instr[FLD_BASE_HI:FLD_BASE_LO]);
   assign rf_raddr_b = compact_reg(instr[FLD_SRC2_HI:FLD_SRC2_LO]);

   assign ofs_now  = mem_offset(instr, op_now);
   assign addr_now = rf_rdata_a + {{(XLEN-2){1'b0}}, ofs_now};

   // shared datapath: load extension while waiting, otherwise the incoming op
   assign unit_op = (state_q == ST_WAIT) ? op_q : op_now;

   operand_ext_unit #(
      .XLEN      (XLEN)
   ) u_ext (
      .op        (unit_op),
      .operand_a (rf_rdata_a),
      .operand_b (rf_rdata_b),
      .load_half (mem_rdata),
      .result    (unit_result)
   );

   // sequencing ---------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (accept && legal_now && is_mem_op(op_now)) begin
               state_d = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (mem_gnt) begin
               state_d = mem_we_q ? ST_IDLE : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (mem_rvalid) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // memory request, captured at acceptance and held until granted -------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         op_q        <= OP_NONE;
         dst_q       <= 5'h00;
         mem_we_q    <= 1'b0;
         mem_half_q  <= SIZE_BYTE;
         mem_addr_q  <= '0;
         mem_wdata_q <= 16'h0000;
      end else if (accept && legal_now && is_mem_op(op_now)) begin
         op_q        <= op_now;
         dst_q       <= compact_reg(instr[FLD_SRC2_HI:FLD_SRC2_LO]);
         mem_we_q    <= (op_now == OP_SB) || (op_now == OP_SH);
         mem_half_q  <= (op_now == OP_SB) ? SIZE_BYTE : SIZE_HALF;
         mem_addr_q  <= addr_now;
         if (op_now == OP_SB) begin
            mem_wdata_q <= {8'h00, rf_rdata_b[7:0]};
         end else begin
            mem_wdata_q <= rf_rdata_b[15:0];
         end
      end
   end

   assign mem_req   = (state_q == ST_ISSUE);
   assign mem_we    = mem_we_q;
   assign mem_half  = mem_half_q;
   assign mem_addr  = mem_addr_q;
   assign mem_wdata = mem_wdata_q;

   // write-back ---------------------------------------------------------
   assign rf_we_d = (accept && legal_now && !is_mem_op(op_now))
                  || (state_q == ST_WAIT && mem_rvalid);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rf_we_q    <= 1'b0;
         rf_waddr_q <= 5'h00;
         rf_wdata_q <= '0;
      end else begin
         rf_we_q <= rf_we_d;
         if (rf_we_d) begin
            // loads target their own field; everything else returns to the combined field
            rf_waddr_q <= (state_q == ST_WAIT) ? dst_q : rf_raddr_a;
            rf_wdata_q <= unit_result;
         end
      end
   end

   assign rf_we    = rf_we_q;
   assign rf_waddr = rf_waddr_q;
   assign rf_wdata = rf_wdata_q;

   // unknown or unsupported encodings are flagged, never executed
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= accept && !legal_now;
      end
   end

   assign instr_illegal = illegal_q;

   // checks -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         last_a_q   <= '0;
         last_b_q   <= '0;
         last_mem_q <= 16'h0000;
      end else begin
         last_a_q   <= rf_rdata_a;
         last_b_q   <= rf_rdata_b;
         last_mem_q <= mem_rdata;
      end
   end

   AST_LHU_ZEXT: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_WAIT && mem_rvalid && op_q == OP_LHU)
      |=> (rf_we && rf_wdata == {{(XLEN-16){1'b0}}, last_mem_q}))
      else $error("unsigned halfword load not zero extended");

   AST_LH_SEXT: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_WAIT && mem_rvalid && op_q == OP_LH)
      |=> (rf_we && rf_wdata == {{(XLEN-16){last_mem_q[15]}}, last_mem_q}))
      else $error("signed halfword load not sign extended");

   AST_ADDR_OFFSET: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && is_mem_op(op_now))
      |=> (mem_req && mem_addr == last_a_q + {{(XLEN-2){1'b0}}, $past(instr[FLD_OFS_HI]),
           ($past(op_now) == OP_SB) && $past(instr[FLD_OFS_LO])}))
      else $error("memory address is not base plus zero-extended offset");

   AST_REG_SUBSET: assert property (@(posedge sys_clk) disable iff (!nrst)
      rf_raddr_a[4:3] == COMPACT_REG_BASE && rf_raddr_b[4:3] == COMPACT_REG_BASE
      && (!rf_we || rf_waddr[4:3] == COMPACT_REG_BASE))
      else $error("register outside the compact subset");

   AST_SB_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_SB)
      |=> (mem_we && mem_half == SIZE_BYTE && mem_wdata == {8'h00, last_b_q[7:0]}))
      else $error("byte store data or size wrong");

   AST_SH_HALF: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_SH)
      |=> (mem_we && mem_half == SIZE_HALF && mem_wdata == last_b_q[15:0]))
      else $error("halfword store data or size wrong");

   AST_UNARY_SAME_REG: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && legal_now && !is_mem_op(op_now))
      |=> (rf_we && rf_waddr == $past(rf_raddr_a) && instr_ready))
      else $error("unary result not written to its source register");

   AST_SEXT_B: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_SEXTB)
      |=> (rf_wdata == {{(XLEN-8){last_a_q[7]}}, last_a_q[7:0]}))
      else $error("byte sign extension wrong");

   AST_NOT_INV: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_NOT)
      |=> (rf_we && rf_wdata == ~last_a_q))
      else $error("complement result wrong");

   AST_MUL_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && legal_now && op_now == OP_MUL)
      |=> (rf_we && rf_wdata == XLEN'(last_a_q * last_b_q)))
      else $error("multiply low half wrong");

   AST_MUL_GATED: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_MUL && !HAS_MUL)
      |=> (instr_illegal && !rf_we))
      else $error("multiply executed without multiplier");

   AST_STORE_NO_WB: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_ISSUE && mem_gnt && mem_we)
      |=> (!rf_we && instr_ready))
      else $error("store caused a register write or did not finish");

   AST_ZEXT_B: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_ZEXTB)
      |=> (rf_we && rf_wdata == {{(XLEN-8){1'b0}}, last_a_q[7:0]}))
      else $error("byte zero extension wrong");

   AST_ZEXT_H: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_ZEXTH)
      |=> (rf_we && rf_wdata == {{(XLEN-16){1'b0}}, last_a_q[15:0]}))
      else $error("halfword zero extension wrong");

   AST_SEXT_H: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_SEXTH)
      |=> (rf_we && rf_wdata == {{(XLEN-16){last_a_q[15]}}, last_a_q[15:0]}))
      else $error("halfword sign extension wrong");

   AST_ZEXT_W: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && legal_now && op_now == OP_ZEXTW)
      |=> (rf_we && rf_wdata == XLEN'(last_a_q[31:0])))
      else $error("word zero extension wrong");

   AST_HALF_OFS: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && (op_now == OP_LHU || op_now == OP_LH || op_now == OP_SH))
      |=> (mem_addr == last_a_q + {{(XLEN-2){1'b0}}, $past(instr[FLD_OFS_HI]), 1'b0}))
      else $error("halfword offset wrong");

   AST_BYTE_OFS: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && op_now == OP_SB)
      |=> (mem_addr == last_a_q + {{(XLEN-2){1'b0}}, $past(instr[FLD_OFS_HI]), $past(instr[FLD_OFS_LO])}))
      else $error("byte store offset wrong");

   AST_REQ_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
      (mem_req && !mem_gnt)
      |=> (mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata)))
      else $error("memory request changed before its grant");

   AST_ILLEGAL_NO_EXEC: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && !legal_now)
      |=> (instr_illegal && !rf_we && !mem_req))
      else $error("illegal encoding was executed");

   AST_MEM_BLOCKS: assert property (@(posedge sys_clk) disable iff (!nrst)
      (accept && legal_now && is_mem_op(op_now))
      |=> (!instr_ready && !rf_we && !instr_illegal))
      else $error("memory form did not hold off fetch");

   AST_GNT_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_ISSUE && mem_gnt && !mem_we)
      |=> (!mem_req && !instr_ready && !rf_we))
      else $error("load did not wait for its data");

   AST_LOAD_WAITS: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_WAIT && !mem_rvalid)
      |=> (!rf_we && !instr_ready))
      else $error("load wrote back before its data arrived");

   AST_LOAD_DEST: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_WAIT && mem_rvalid)
      |=> (rf_we && rf_waddr == dst_q && instr_ready))
      else $error("load wrote the wrong register");

endmodule : compact_ext_instr_exec

// ===== verilog/compact_ext_pkg.sv
// constants, types and decode helpers for the compact extend/multiply executor
package compact_ext_pkg;

   localparam int          XLEN_DEFAULT     = 32;
   localparam int          XLEN_WIDE        = 64;

   // quadrant and function codes
   localparam logic [1:0]  QUAD_MEM         = 2'h0;
   localparam logic [1:0]  QUAD_ALU         = 2'h1;
   localparam logic [5:0]  FN6_LOAD_HALF    = 6'h21;
   localparam logic [5:0]  FN6_STORE_BYTE   = 6'h22;
   localparam logic [5:0]  FN6_STORE_HALF   = 6'h23;
   localparam logic [5:0]  FN6_ARITH        = 6'h27;
   localparam logic [1:0]  FN2_UNARY        = 2'h3;
   localparam logic [1:0]  FN2_MUL          = 2'h2;
   localparam logic [2:0]  UN_ZEXT_B        = 3'h0;
   localparam logic [2:0]  UN_SEXT_B        = 3'h1;
   localparam logic [2:0]  UN_ZEXT_H        = 3'h2;
   localparam logic [2:0]  UN_SEXT_H        = 3'h3;
   localparam logic [2:0]  UN_ZEXT_W        = 3'h4;
   localparam logic [2:0]  UN_NOT           = 3'h5;

   // field positions in the 16-bit encoding
   localparam int          FLD_FN6_HI       = 15;
   localparam int          FLD_FN6_LO       = 10;
   localparam int          FLD_BASE_HI      = 9;
   localparam int          FLD_BASE_LO      = 7;
   localparam int          FLD_SIGN         = 6;
   localparam int          FLD_OFS_HI       = 5;
   localparam int          FLD_OFS_LO       = 6;
   localparam int          FLD_FN2_HI       = 6;
   localparam int          FLD_FN2_LO       = 5;
   localparam int          FLD_SRC2_HI      = 4;
   localparam int          FLD_SRC2_LO      = 2;
   localparam int          FLD_QUAD_HI      = 1;
   localparam int          FLD_QUAD_LO      = 0;

   localparam logic [1:0]  COMPACT_REG_BASE = 2'h1;
   localparam logic        SIZE_BYTE        = 1'b0;
   localparam logic        SIZE_HALF        = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_ISSUE = 2'h1,
      ST_WAIT  = 2'h3
   } state_e;

   typedef enum logic [3:0] {
      OP_NONE  = 4'h0,
      OP_LHU   = 4'h1,
      OP_LH    = 4'h2,
      OP_SB    = 4'h3,
      OP_SH    = 4'h4,
      OP_ZEXTB = 4'h5,
      OP_SEXTB = 4'h6,
      OP_ZEXTH = 4'h7,
      OP_SEXTH = 4'h8,
      OP_ZEXTW = 4'h9,
      OP_NOT   = 4'hA,
      OP_MUL   = 4'hB
   } op_e;

   function automatic op_e decode_op(input logic [15:0] ins);
      logic [5:0] fn6;
      logic [1:0] quad;
      logic [1:0] fn2;
      fn6  = ins[FLD_FN6_HI:FLD_FN6_LO];
      quad = ins[FLD_QUAD_HI:FLD_QUAD_LO];
      fn2  = ins[FLD_FN2_HI:FLD_FN2_LO];
      decode_op = OP_NONE;
      if (quad == QUAD_MEM) begin
         if (fn6 == FN6_LOAD_HALF) decode_op = ins[FLD_SIGN] ? OP_LH : OP_LHU;
         else if (fn6 == FN6_STORE_BYTE) decode_op = OP_SB;
         else if (fn6 == FN6_STORE_HALF && !ins[FLD_SIGN]) decode_op = OP_SH;
      end else if (quad == QUAD_ALU && fn6 == FN6_ARITH) begin
         if (fn2 == FN2_MUL) decode_op = OP_MUL;
         else if (fn2 == FN2_UNARY) begin
            unique case (ins[FLD_SRC2_HI:FLD_SRC2_LO])
               UN_ZEXT_B: decode_op = OP_ZEXTB;
               UN_SEXT_B: decode_op = OP_SEXTB;
               UN_ZEXT_H: decode_op = OP_ZEXTH;
               UN_SEXT_H: decode_op = OP_SEXTH;
               UN_ZEXT_W: decode_op = OP_ZEXTW;
               UN_NOT:    decode_op = OP_NOT;
               default:   decode_op = OP_NONE;
            endcase
         end
      end
   endfunction : decode_op

   // field value n names architectural register 8 + n
   function automatic logic [4:0] compact_reg(input logic [2:0] fld);
      compact_reg = {COMPACT_REG_BASE, fld};
   endfunction : compact_reg

   function automatic logic is_mem_op(input op_e op);
      is_mem_op = (op == OP_LHU) || (op == OP_LH) || (op == OP_SB) || (op == OP_SH);
   endfunction : is_mem_op

   // zero-extended offset: bit1 from ins[5], bit0 from ins[6] only for byte store
   function automatic logic [1:0] mem_offset(input logic [15:0] ins, input op_e op);
      mem_offset = {ins[FLD_OFS_HI], (op == OP_SB) ? ins[FLD_OFS_LO] : 1'b0};
   endfunction : mem_offset

endpackage : compact_ext_pkg

// ===== verilog/operand_ext_unit.sv
// combinational extend, complement, multiply and load-extension datapath
module operand_ext_unit
   import compact_ext_pkg::*;
#(
   parameter int XLEN = XLEN_DEFAULT
) (
   input  wire op_e              op,
   input  wire logic [XLEN-1:0]  operand_a,
   input  wire logic [XLEN-1:0]  operand_b,
   input  wire logic [15:0]      load_half,
   output logic      [XLEN-1:0]  result
);

   logic [XLEN-1:0] product;

   // only the low half of the product is kept, so signedness does not matter
   assign product = operand_a * operand_b;

   always_comb begin
      unique case (op)
         OP_LHU:   result = {{(XLEN-16){1'b0}}, load_half};
         OP_LH:    result = {{(XLEN-16){load_half[15]}}, load_half};
         OP_ZEXTB: result = {{(XLEN-8){1'b0}}, operand_a[7:0]};
         OP_SEXTB: result = {{(XLEN-8){operand_a[7]}}, operand_a[7:0]};
         OP_ZEXTH: result = {{(XLEN-16){1'b0}}, operand_a[15:0]};
         OP_SEXTH: result = {{(XLEN-16){operand_a[15]}}, operand_a[15:0]};
         OP_ZEXTW: result = {{(XLEN-32){1'b0}}, operand_a[31:0]};
         OP_NOT:   result = ~operand_a;
         OP_MUL:   result = product;
         default:  result = '0;
      endcase
   end

endmodule : operand_ext_unit
